// File: shared/irq_bank_pkg.sv
// Register map, bit layout, source numbers and event carrier of the interrupt bank
//
// Contract
// [R01] Edge field: 00 off, 01 rise, 10 fall, 11 both
// [R02] Edge fields at 5:4, 3:2, 1:0; 7:6 zero
// [R03] Control A bit 0 gates every interrupt
// [R04] Control A: protection flags 6..4, enables 3..1
// [R05] Control B: pin0, undervoltage, overvoltage 1 flags/enables
// [R06] Control C: group, pin2, pin1 flags/enables
// [R07] Control D: serial, timebases, low supply flags/enables
// [R08] Group A: eeprom, std timer flags/enables
// [R09] Source event sets its flag; one means pending
// [R10] All implemented bits read/write, zero after reset
// [R11] Group B: converter, periodic timer flags/enables
// [R12] Disabled flag stays set, raises nothing
// [R13] Service clears global enable; flags still set
// [R14] Service clears pin and protection flags
// [R15] Enabled pending group member sets group flag
// [R16] Pins synchronised; chosen edge sets flag
package irq_bank_pkg;

    // Register indices; byte address is index times four
    localparam logic [2:0] REG_EDGE    = 3'h0;
    localparam logic [2:0] REG_CTRL_A  = 3'h1;
    localparam logic [2:0] REG_CTRL_B  = 3'h2;
    localparam logic [2:0] REG_CTRL_C  = 3'h3;
    localparam logic [2:0] REG_CTRL_D  = 3'h4;
    localparam logic [2:0] REG_GROUP_A = 3'h5;
    localparam logic [2:0] REG_GROUP_B = 3'h6;
    localparam int         REG_COUNT   = 7;
    localparam logic [7:0] ADDR_LAST   = 8'h18;

    // Implemented bits per register
    localparam logic [7:0] REG_MASK [0:6] = '{8'h3F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h77, 8'h77};
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions
    localparam int BIT_GLOBAL_EN  = 0;
    localparam int BIT_GROUP0_FLG = 6;
    localparam int BIT_GROUP1_FLG = 7;
    localparam int PIN0_SEL_LSB   = 0;
    localparam int PIN1_SEL_LSB   = 2;
    localparam int PIN2_SEL_LSB   = 4;

    // Edge select codes
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Primary sources, lowest number served first
    localparam int         SRC_COUNT     = 15;
    localparam logic [3:0] SRC_OCP0      = 4'h0;
    localparam logic [3:0] SRC_OVP0      = 4'h2;
    localparam logic [3:0] SRC_OVP1      = 4'h3;
    localparam logic [3:0] SRC_PIN0      = 4'h6;
    localparam logic [3:0] SRC_PIN1      = 4'h7;
    localparam logic [3:0] SRC_PIN2      = 4'h8;
    localparam logic [3:0] SRC_NONE      = 4'hF;

    // One-cycle event pulses from the peripherals
    typedef struct packed {
        logic [1:0] overcurrent;
        logic [1:0] overvoltage;
        logic [1:0] undervoltage;
        logic [1:0] timebase;
        logic       low_supply;
        logic       serial_module;
        logic       eeprom_done;
        logic       std_timer_a;
        logic       std_timer_p;
        logic       periodic_timer_a;
        logic       periodic_timer_p;
        logic       converter_done;
    } irq_events_s;

endpackage : irq_bank_pkg

// File: hw/pin_edge_detect.sv
// Synchroniser and edge selector for one external interrupt pin
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect (
    // Clock, reset, enable
    input  wire logic       ref_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       ce_in,
    // Pin and edge field
    input  wire logic       pin_in,
    input  wire logic [1:0] sel_in,
    // Chosen edge seen
    output logic            edge_out
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else if (ce_in) begin
            sync1_reg <= pin_in;   // [R16]
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    always_comb begin
        case (sel_in)   // [R01]
            irq_bank_pkg::EDGE_RISE: edge_out = sync2_reg & ~prev_reg;
            irq_bank_pkg::EDGE_FALL: edge_out = ~sync2_reg & prev_reg;
            irq_bank_pkg::EDGE_BOTH: edge_out = sync2_reg ^ prev_reg;
            default:                 edge_out = 1'b0;
        endcase
    end

    edge_off_a: assert property ( // [R01]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        sel_in == irq_bank_pkg::EDGE_OFF |-> !edge_out)
        else $error("edge seen while pin disabled");

    edge_rise_a: assert property ( // [R01]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        sel_in == irq_bank_pkg::EDGE_RISE && edge_out |-> sync2_reg && !prev_reg)
        else $error("rising select fired without rising edge");

endmodule : pin_edge_detect
`default_nettype wire

// File: hw/interrupt_flag_enable_bank.sv
// Interrupt request and enable register bank with APB access and service port
`timescale 1ns/1ps
`default_nettype none
module interrupt_flag_enable_bank (
    // Clock, reset, enable
    input  wire logic                      ref_clk_in,
    input  wire logic                      rstn_in,
    input  wire logic                      ce_in,

    // APB slave
    input  wire logic                      psel_in,
    input  wire logic                      penable_in,
    input  wire logic                      pwrite_in,
    input  wire logic [7:0]                paddr_in,
    input  wire logic [31:0]               pwdata_in,
    input  wire logic [3:0]                pstrb_in,
    output logic [31:0]                    prdata_out,
    output logic                           pready_out,
    output logic                           pslverr_out,

    // Event sources
    input  wire irq_bank_pkg::irq_events_s events_in,
    input  wire logic [2:0]                external_irq_pins_in,

    // Processor core
    input  wire logic                      service_ack_in,
    input  wire logic [3:0]                service_src_in,
    output logic                           irq_out,
    output logic [3:0]                     irq_src_out
);

    // Register storage
    logic [7:0]  regs_reg  [0:6];
    logic [7:0]  regs_next [0:6];
    logic [7:0]  set_vec   [0:6];
    logic [7:0]  clr_vec   [0:6];

    // Bus side
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [2:0]  reg_idx;
    logic        addr_hit;
    logic        setup_phase;
    logic        write_take;

    // Interrupt side
    logic [2:0]  pin_edge;
    logic [14:0] pending;
    logic        group0_req;
    logic        group1_req;
    logic        irq_reg;
    logic [3:0]  irq_src_reg;
    logic [3:0]  src_pick;

    // Pin edge detectors
    pin_edge_detect u_pin0 (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .ce_in      (ce_in),
        .pin_in     (external_irq_pins_in[0]),
        .sel_in     (regs_reg[irq_bank_pkg::REG_EDGE][irq_bank_pkg::PIN0_SEL_LSB +: 2]),
        .edge_out   (pin_edge[0])
    );

    pin_edge_detect u_pin1 (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .ce_in      (ce_in),
        .pin_in     (external_irq_pins_in[1]),
        .sel_in     (regs_reg[irq_bank_pkg::REG_EDGE][irq_bank_pkg::PIN1_SEL_LSB +: 2]),
        .edge_out   (pin_edge[1])
    );

    pin_edge_detect u_pin2 (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .ce_in      (ce_in),
        .pin_in     (external_irq_pins_in[2]),
        .sel_in     (regs_reg[irq_bank_pkg::REG_EDGE][irq_bank_pkg::PIN2_SEL_LSB +: 2]),
        .edge_out   (pin_edge[2])
    );

    // Address decode
    assign reg_idx     = paddr_in[4:2];
    assign setup_phase = psel_in & ~penable_in;

    always_comb begin
        if (paddr_in[1:0] != 2'h0) begin
            addr_hit = 1'b0;
        end else if (paddr_in > irq_bank_pkg::ADDR_LAST) begin
            addr_hit = 1'b0;
        end else begin
            addr_hit = 1'b1;
        end
    end

    // Write takes effect at the access edge, lane 0 only
    assign write_take = psel_in & penable_in & pready_reg & pwrite_in
                      & addr_hit & pstrb_in[0];

    // Group requests: an enabled member is pending
    assign group0_req = |(regs_reg[irq_bank_pkg::REG_GROUP_A][6:4]
                        & regs_reg[irq_bank_pkg::REG_GROUP_A][2:0]);   // [R15]
    assign group1_req = |(regs_reg[irq_bank_pkg::REG_GROUP_B][6:4]
                        & regs_reg[irq_bank_pkg::REG_GROUP_B][2:0]);   // [R15]

    // Hardware set vectors, flag positions per register layout
    always_comb begin
        set_vec[irq_bank_pkg::REG_EDGE]    = 8'h00;
        set_vec[irq_bank_pkg::REG_CTRL_A]  = {1'b0, events_in.overvoltage[0],
                                              events_in.overcurrent, 4'h0};   // [R04] [R09]
        set_vec[irq_bank_pkg::REG_CTRL_B]  = {pin_edge[0], events_in.undervoltage,
                                              events_in.overvoltage[1], 4'h0}; // [R05] [R09]
        set_vec[irq_bank_pkg::REG_CTRL_C]  = {group1_req, group0_req,
                                              pin_edge[2:1], 4'h0};            // [R06] [R16]
        set_vec[irq_bank_pkg::REG_CTRL_D]  = {events_in.serial_module, events_in.timebase,
                                              events_in.low_supply, 4'h0};     // [R07] [R09]
        set_vec[irq_bank_pkg::REG_GROUP_A] = {1'b0, events_in.eeprom_done,
                                              events_in.std_timer_a,
                                              events_in.std_timer_p, 4'h0};    // [R08] [R09]
        set_vec[irq_bank_pkg::REG_GROUP_B] = {1'b0, events_in.converter_done,
                                              events_in.periodic_timer_a,
                                              events_in.periodic_timer_p, 4'h0}; // [R11] [R09]
    end

    // Service clears: global enable always, own flag for pins and protection
    always_comb begin
        for (int i = 0; i < irq_bank_pkg::REG_COUNT; i++) begin
            clr_vec[i] = 8'h00;
        end
        if (service_ack_in) begin
            clr_vec[irq_bank_pkg::REG_CTRL_A][irq_bank_pkg::BIT_GLOBAL_EN] = 1'b1;   // [R13]
            if (service_src_in <= irq_bank_pkg::SRC_OVP0) begin
                clr_vec[irq_bank_pkg::REG_CTRL_A][3'(service_src_in) + 3'h4] = 1'b1; // [R14]
            end else if (service_src_in <= irq_bank_pkg::SRC_PIN0) begin
                clr_vec[irq_bank_pkg::REG_CTRL_B][3'(service_src_in) + 3'h1] = 1'b1; // [R14]
            end else if (service_src_in <= irq_bank_pkg::SRC_PIN2) begin
                clr_vec[irq_bank_pkg::REG_CTRL_C][3'(service_src_in) - 3'h3] = 1'b1; // [R14]
            end
        end
    end

    // Next value: write or hold, then clear, then set; set wins
    always_comb begin
        for (int i = 0; i < irq_bank_pkg::REG_COUNT; i++) begin
            regs_next[i] = ((write_take && reg_idx == 3'(i)) ? pwdata_in[7:0] : regs_reg[i]);
            regs_next[i] = ((regs_next[i] & ~clr_vec[i]) | set_vec[i])
                         & irq_bank_pkg::REG_MASK[i];   // [R02] [R10] [R13]
        end
    end

    // Register bank
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < irq_bank_pkg::REG_COUNT; i++) begin
                regs_reg[i] <= irq_bank_pkg::REG_RESET;   // [R10]
            end
        end else if (ce_in) begin
            for (int i = 0; i < irq_bank_pkg::REG_COUNT; i++) begin
                regs_reg[i] <= regs_next[i];
            end
        end
    end

    // APB answer: ready one cycle after setup, data caught in setup
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end else if (ce_in) begin
            pready_reg <= setup_phase;
            if (setup_phase) begin
                pslverr_reg <= ~addr_hit;
                if (addr_hit && !pwrite_in) begin
                    prdata_reg <= {24'h000000, regs_reg[reg_idx]};
                end else begin
                    prdata_reg <= 32'h00000000;
                end
            end
        end
    end

    // Pending primary requests, flags upper field against enables below
    assign pending = {regs_reg[irq_bank_pkg::REG_CTRL_D][7:4]
                      & regs_reg[irq_bank_pkg::REG_CTRL_D][3:0],
                      regs_reg[irq_bank_pkg::REG_CTRL_C][7:4]
                      & regs_reg[irq_bank_pkg::REG_CTRL_C][3:0],
                      regs_reg[irq_bank_pkg::REG_CTRL_B][7:4]
                      & regs_reg[irq_bank_pkg::REG_CTRL_B][3:0],
                      regs_reg[irq_bank_pkg::REG_CTRL_A][6:4]
                      & regs_reg[irq_bank_pkg::REG_CTRL_A][3:1]};   // [R12]

    // Lowest numbered pending source
    always_comb begin
        src_pick = irq_bank_pkg::SRC_NONE;
        for (int i = irq_bank_pkg::SRC_COUNT - 1; i >= 0; i--) begin
            if (pending[i]) begin
                src_pick = 4'(i);
            end
        end
    end

    // Interrupt request to the core
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_reg     <= 1'b0;
            irq_src_reg <= irq_bank_pkg::SRC_NONE;
        end else if (ce_in) begin
            irq_reg     <= regs_reg[irq_bank_pkg::REG_CTRL_A][irq_bank_pkg::BIT_GLOBAL_EN]
                         & (|pending);   // [R03] [R12]
            irq_src_reg <= src_pick;
        end
    end

    assign prdata_out  = prdata_reg;
    assign pready_out  = pready_reg;
    assign pslverr_out = pslverr_reg;
    assign irq_out     = irq_reg;
    assign irq_src_out = irq_src_reg;

    // Checks
    global_gate_a: assert property ( // [R03]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ce_in && !regs_reg[irq_bank_pkg::REG_CTRL_A][irq_bank_pkg::BIT_GLOBAL_EN]
        |=> !irq_out)
        else $error("interrupt raised with global enable low");

    masked_flag_a: assert property ( // [R12]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ce_in && pending == 15'h0000 |=> !irq_out && irq_src_out == irq_bank_pkg::SRC_NONE)
        else $error("interrupt raised with nothing enabled");

    irq_raise_a: assert property ( // [R03]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ce_in && regs_reg[irq_bank_pkg::REG_CTRL_A][irq_bank_pkg::BIT_GLOBAL_EN]
        && pending[irq_bank_pkg::SRC_PIN0] |=> irq_out)
        else $error("enabled pending pin 0 raised no interrupt");

    service_emi_a: assert property ( // [R13]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ce_in && service_ack_in
        |=> !regs_reg[irq_bank_pkg::REG_CTRL_A][irq_bank_pkg::BIT_GLOBAL_EN] ##1 !irq_out)
        else $error("service left global enable set");

    service_keep_a: assert property ( // [R13]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ce_in && service_ack_in && events_in.timebase[0]
        |=> regs_reg[irq_bank_pkg::REG_CTRL_D][5])
        else $error("event during service was lost");

    service_flag_a: assert property ( // [R14]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ce_in && service_ack_in && service_src_in == irq_bank_pkg::SRC_OVP1
        && !events_in.overvoltage[1] && !write_take
        |=> !regs_reg[irq_bank_pkg::REG_CTRL_B][4])
        else $error("serviced protection flag not cleared");

    event_set_a: assert property ( // [R09]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ce_in && events_in.overcurrent[1] |=> regs_reg[irq_bank_pkg::REG_CTRL_A][5])
        else $error("overcurrent event did not set its flag");

    pin_flag_a: assert property ( // [R16]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ce_in && pin_edge[1] |=> regs_reg[irq_bank_pkg::REG_CTRL_C][4])
        else $error("pin 1 edge did not set its flag");

    group_flag_a: assert property ( // [R15]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ce_in && group1_req |=> regs_reg[irq_bank_pkg::REG_CTRL_C][irq_bank_pkg::BIT_GROUP1_FLG])
        else $error("group 1 member pending without group flag");

    reserved_zero_a: assert property ( // [R02]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        regs_reg[irq_bank_pkg::REG_EDGE][7:6] == 2'h0
        && regs_reg[irq_bank_pkg::REG_CTRL_A][7] == 1'b0)
        else $error("unimplemented bit set");

    group_layout_a: assert property ( // [R08]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (regs_reg[irq_bank_pkg::REG_GROUP_A] & 8'h88) == 8'h00
        && (regs_reg[irq_bank_pkg::REG_GROUP_B] & 8'h88) == 8'h00)
        else $error("group register reserved bit set");

    write_store_a: assert property ( // [R10]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ce_in && write_take && reg_idx == irq_bank_pkg::REG_CTRL_D && !service_ack_in
        |=> regs_reg[irq_bank_pkg::REG_CTRL_D][3:0] == $past(pwdata_in[3:0]))
        else $error("enable write not stored");

    apb_ready_a: assert property ( // [R10]
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ce_in && setup_phase ##1 ce_in && psel_in && penable_in |-> pready_out)
        else $error("access phase without ready");

endmodule : interrupt_flag_enable_bank
`default_nettype wire

// File: tb/core_event_model.sv
// Behavioural processor core that acknowledges pending interrupts
`timescale 1ns/1ps
`default_nettype none
module core_event_model (
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rstn_in,
    // Bench control
    input  wire logic       auto_ack_in,
    input  wire logic [3:0] delay_in,
    // Request from the bank
    input  wire logic       irq_in,
    input  wire logic [3:0] irq_src_in,
    // Service acknowledge
    output logic            service_ack_out,
    output logic [3:0]      service_src_out
);
    logic [3:0] wait_reg;
    logic [1:0] hold_reg;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            service_ack_out <= 1'b0;
            service_src_out <= 4'hF;
            wait_reg        <= 4'h0;
            hold_reg        <= 2'h0;
        end else begin
            service_ack_out <= 1'b0;
            // Idle source lines keep moving
            service_src_out <= ~service_src_out;
            if (hold_reg != 2'h0) begin
                hold_reg <= hold_reg - 2'h1;
                wait_reg <= 4'h0;
            end else if (auto_ack_in && irq_in) begin
                if (wait_reg == delay_in) begin
                    service_ack_out <= 1'b1;
                    service_src_out <= irq_src_in;
                    hold_reg        <= 2'h3;
                    wait_reg        <= 4'h0;
                end else begin
                    wait_reg <= wait_reg + 4'h1;
                end
            end else begin
                wait_reg <= 4'h0;
            end
        end
    end
endmodule : core_event_model
`default_nettype wire

// File: tb/interrupt_flag_enable_bank_tb.sv
// Self-checking bench for the interrupt flag and enable bank
`timescale 1ns/1ps
`default_nettype none
module interrupt_flag_enable_bank_tb;
    localparam int LIMIT = 20000;
    localparam logic [7:0] EV_ADDR [0:15] = '{8'h18, 8'h18, 8'h18, 8'h14, 8'h14, 8'h14,
        8'h10, 8'h10, 8'h10, 8'h10, 8'h08, 8'h08, 8'h04, 8'h08, 8'h04, 8'h04};
    localparam int EV_BIT [0:15] = '{6, 4, 5, 4, 5, 6, 7, 4, 5, 6, 5, 6, 6, 4, 4, 5};
    localparam logic [7:0] PIN_ADDR [0:2] = '{8'h08, 8'h0C, 8'h0C};
    localparam int PIN_BIT [0:2] = '{7, 4, 5};

    logic                      clk = 1'b0;
    logic                      rstn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]                paddr;
    logic [31:0]               pwdata, prdata;
    logic [3:0]                pstrb, svc_src, irq_src, ack_delay;
    irq_bank_pkg::irq_events_s events;
    logic [2:0]                pins;
    logic                      svc_ack, irq, auto_ack;
    logic                      ce = 1'b1;
    int                        miscompares = 0;
    int                        check_count = 0;
    int                        cycles = 0;

    always #10 clk = ~clk;

    interrupt_flag_enable_bank u_dut (.ref_clk_in(clk), .rstn_in(rstn), .ce_in(ce),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .events_in(events), .external_irq_pins_in(pins),
        .service_ack_in(svc_ack), .service_src_in(svc_src), .irq_out(irq),
        .irq_src_out(irq_src));

    core_event_model u_core (.ref_clk_in(clk), .rstn_in(rstn), .auto_ack_in(auto_ack),
        .delay_in(ack_delay), .irq_in(irq), .irq_src_in(irq_src),
        .service_ack_out(svc_ack), .service_src_out(svc_src));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] v,
                        input logic [3:0] s, output logic [31:0] d, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, v};
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [31:0] d;
        logic e;
        xfer(1'b1, a, v, 4'hF, d, e);
    endtask : wr

    task automatic pulse(input logic [15:0] v);
        events <= irq_bank_pkg::irq_events_s'(v);
        @(posedge clk);
        events <= '0;
        @(posedge clk);
    endtask : pulse

    function automatic logic [3:0] exp_src(logic [7:0] a, logic [7:0] b, logic [7:0] c,
                                           logic [7:0] d);
        logic [14:0] p;
        p[2:0] = a[6:4] & a[3:1];
        p[6:3] = b[7:4] & b[3:0];
        p[8:7] = c[5:4] & c[1:0];
        p[10:9] = c[7:6] & c[3:2];
        p[14:11] = d[7:4] & d[3:0];
        exp_src = 4'hF;
        for (int k = 14; k >= 0; k--) if (p[k]) exp_src = 4'(k);
    endfunction : exp_src

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        logic [31:0] d;
        logic        e;
        logic [7:0]  r [0:3];
        logic [3:0]  s;
        void'($urandom(65));
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {events, pins, auto_ack, ack_delay, rstn} = '0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, 8'(i * 4), 8'h00, 4'hF, d, e);
            chk("reset value", 32'h0, d);
        end
        chk("reset source", 32'hF, 32'(irq_src));
        xfer(1'b0, 8'h1C, 8'h00, 4'hF, d, e);
        chk("unmapped error", 32'h1, 32'(e));
        xfer(1'b0, 8'h06, 8'h00, 4'hF, d, e);
        chk("misaligned error", 32'h1, 32'(e));
        xfer(1'b1, 8'h10, 8'hFF, 4'hE, d, e);
        xfer(1'b0, 8'h10, 8'h00, 4'hF, d, e);
        chk("lane off write", 32'h0, d);
        $display("test refusals done");
        for (int i = 0; i < 7; i++) begin
            r[0] = (i == 0) ? 8'hFF : 8'($urandom);
            wr(8'(i * 4), r[0]);
            xfer(1'b0, 8'(i * 4), 8'h00, 4'hF, d, e);
            chk("read back", {24'h0, r[0] & irq_bank_pkg::REG_MASK[i]}, d);
            wr(8'(i * 4), 8'h00);
        end
        for (int i = 0; i < 7; i++) wr(8'(i * 4), 8'h00);
        $display("test access done");
        wr(8'h04, 8'h01);
        for (int i = 0; i < 16; i++) begin
            pulse(16'h1 << i);
            xfer(1'b0, EV_ADDR[i], 8'h00, 4'hF, d, e);
            chk("event flag", 32'h1 << EV_BIT[i], d & (32'h1 << EV_BIT[i]));
            chk("masked irq", 32'h0, 32'(irq));
            wr(EV_ADDR[i], {7'h00, EV_ADDR[i] == 8'h04});
        end
        // Clock enable low drops the event
        ce <= 1'b0;
        pulse(16'h0080);
        ce <= 1'b1;
        xfer(1'b0, 8'h10, 8'h00, 4'hF, d, e);
        chk("frozen flag", 32'h0, d);
        $display("test events done");
        wr(8'h14, 8'h44);
        wr(8'h18, 8'h11);
        xfer(1'b0, 8'h0C, 8'h00, 4'hF, d, e);
        chk("group flags", 32'hC0, d & 32'hC0);
        wr(8'h14, 8'h00);
        wr(8'h18, 8'h00);
        wr(8'h0C, 8'h00);
        $display("test groups done");
        for (int n = 0; n < 12; n++) begin
            for (int k = 0; k < 4; k++) begin
                r[k] = (n == 0) ? 8'hFF : 8'($urandom);
                r[k] = r[k] & irq_bank_pkg::REG_MASK[k + 1];
                wr(8'(4 * (k + 1)), r[k]);
            end
            repeat (3) @(posedge clk);
            s = exp_src(r[0], r[1], r[2], r[3]);
            chk("irq level", 32'(r[0][0] && s != 4'hF), 32'(irq));
            chk("irq source", 32'(s), 32'(irq_src));
            for (int k = 0; k < 4; k++) wr(8'(4 * (k + 1)), 8'h00);
        end
        $display("test priority done");
        for (int p = 0; p < 3; p++) begin
            for (int m = 0; m < 4; m++) begin
                wr(8'h00, 8'(m << (2 * p)));
                pins[p] <= 1'b1;
                repeat (5) @(posedge clk);
                xfer(1'b0, PIN_ADDR[p], 8'h00, 4'hF, d, e);
                chk("rise flag", 32'(m & 1), 32'(d[PIN_BIT[p]]));
                wr(PIN_ADDR[p], 8'h00);
                pins[p] <= 1'b0;
                repeat (5) @(posedge clk);
                xfer(1'b0, PIN_ADDR[p], 8'h00, 4'hF, d, e);
                chk("fall flag", 32'(m >> 1), 32'(d[PIN_BIT[p]]));
                wr(PIN_ADDR[p], 8'h00);
            end
        end
        wr(8'h00, 8'h00);
        $display("test pins done");
        auto_ack <= 1'b1;
        for (int n = 0; n < 2; n++) begin
            ack_delay <= 4'(n * 6);
            wr(8'h04, 8'h05);
            wr(8'h08, 8'h01);
            pulse((n == 0) ? 16'h8000 : 16'h2000);
            // Time base event held across the service
            events <= irq_bank_pkg::irq_events_s'(16'h0100);
            repeat (14) @(posedge clk);
            events <= '0;
            xfer(1'b0, 8'h04, 8'h00, 4'hF, d, e);
            chk("serviced control", 32'h04, d);
            xfer(1'b0, 8'h08, 8'h00, 4'hF, d, e);
            chk("serviced protection", 32'h01, d);
            chk("irq after service", 32'h0, 32'(irq));
            wr(8'h10, 8'h02);
            wr(8'h04, 8'h01);
            pulse(16'h0100);
            repeat (14) @(posedge clk);
            xfer(1'b0, 8'h10, 8'h00, 4'hF, d, e);
            chk("kept flag", 32'h22, d);
            xfer(1'b0, 8'h04, 8'h00, 4'hF, d, e);
            chk("global cleared", 32'h0, d);
            wr(8'h10, 8'h00);
        end
        $display("test service done");
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        xfer(1'b0, 8'h08, 8'h00, 4'hF, d, e);
        chk("reset mid run", 32'h0, d);
        chk("reset irq source", 32'hF, 32'(irq_src));
        $display("test reset done");
        end_sim();
    end
endmodule : interrupt_flag_enable_bank_tb
`default_nettype wire
